// file: hdl/rtc_tc_pkg.sv
/*
  Constants for the temperature compensation control block: register
  offsets, field positions, reset values, timing figures and states.
  Assumes a single 125 MHz clock and an 8-bit register port.
*/
package rtc_tc_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_COLD_COEFF = 8'h0C;
  localparam logic [7:0] ADDR_CTRL_GAIN = 8'h0D;
  localparam logic [7:0] ADDR_STATUS = 8'h1F;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int BIT_THERMAL_ON = 7;
  localparam int BIT_BATT_ON = 6;
  localparam int BIT_BATT_RATE = 5;
  localparam int GAIN_MSB = 4;
  localparam logic [7:0] COLD_COEFF_RST = 8'h00;
  localparam logic [7:0] CTRL_GAIN_RST = 8'h00;
  localparam logic [7:0] RDATA_NONE = 8'h00;

  // ------------------------------------------------------------
  // Trim decode
  // ------------------------------------------------------------
  localparam logic signed [6:0] TRIM_POS_TOP = 7'sh20;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int SECOND_NS = 1_000_000_000;
  localparam int CYCLES_PER_SECOND = SECOND_NS / CLOCK_PERIOD_NS;
  localparam int PERIOD_SLOW_MIN = 10;
  localparam int PERIOD_FAST_MIN = 1;
  localparam int SECONDS_PER_MIN = 60;
  localparam logic [9:0] PERIOD_SLOW_S = 10'(PERIOD_SLOW_MIN * SECONDS_PER_MIN);
  localparam logic [9:0] PERIOD_FAST_S = 10'(PERIOD_FAST_MIN * SECONDS_PER_MIN);

  // ------------------------------------------------------------
  // Conversion sequencer states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV1 = 3'b010,
    ST_CONV2 = 3'b100
  } conv_state_t;

endpackage : rtc_tc_pkg

// file: hdl/rtc_temp_comp.sv
/*
  Temperature compensation control: coefficient and control registers,
  trim decode, sensing enables, two-conversion averaging and the
  battery-mode sense period.
  Assumes the converter, sensor and compensation datapath sit outside;
  the battery level flag is already synchronous to i_clock.
*/
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module rtc_temp_comp
  import rtc_tc_pkg::*;
#(
  parameter int SECOND_CYCLES = CYCLES_PER_SECOND
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Supply state
  input wire logic i_battery_mode,
  input wire logic i_vbat_low,
  // Initial trims and compensated trims
  input wire logic [5:0] i_initial_analog_trim,
  input wire logic [4:0] i_initial_digital_trim,
  input wire logic [5:0] i_comp_analog_trim,
  input wire logic [4:0] i_comp_digital_trim,
  // Curvature inputs
  input wire logic [7:0] i_hot_coeff,
  input wire logic [9:0] i_turnover_temp,
  // Converter
  input wire logic i_conv_done,
  input wire logic [9:0] i_conv_result,
  output logic o_conv_start,
  output logic o_sensor_on,
  // Compensation outputs
  output logic o_comp_active,
  output logic [5:0] o_analog_trim,
  output logic [4:0] o_digital_trim,
  output logic signed [6:0] o_analog_step,
  output logic [4:0] o_gain,
  output logic [7:0] o_curv_coeff,
  output logic o_cold_span,
  output logic [9:0] o_temp_result
);

  // ------------------------------------------------------------
  // Trim code to signed step count
  // ------------------------------------------------------------
  function automatic logic signed [6:0] trim_step(input logic [5:0] code);
    logic signed [6:0] mag;
    mag = $signed({2'b00, code[4:0]});
    if (code[5]) begin
      trim_step = -mag;
    end else begin
      trim_step = TRIM_POS_TOP - mag;
    end
  endfunction : trim_step

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] cold_q, cold_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] rdata_q, rdata_d;
  logic thermal_on, batt_on, batt_rate;
  logic tse_rise;
  logic start_ok;
  conv_state_t state_q, state_d;
  logic sense_active;

  assign thermal_on = ctrl_q[BIT_THERMAL_ON];
  assign batt_on = ctrl_q[BIT_BATT_ON];
  assign batt_rate = ctrl_q[BIT_BATT_RATE];
  // Turning sensing on from off kicks one averaging cycle
  assign tse_rise = i_wr && (i_addr == ADDR_CTRL_GAIN) && i_wdata[BIT_THERMAL_ON] && !thermal_on;
  // Battery permission comes from the byte being written, not the old register
  assign start_ok = tse_rise && (!i_battery_mode || (i_wdata[BIT_BATT_ON] && !i_vbat_low));

  // Writes are taken at any time; gating them is software's duty
  always_comb begin
    cold_d = cold_q;
    ctrl_d = ctrl_q;
    rdata_d = RDATA_NONE;
    if (i_wr && i_addr == ADDR_COLD_COEFF) begin
      cold_d = i_wdata;
    end else if (i_wr && i_addr == ADDR_CTRL_GAIN) begin
      ctrl_d = i_wdata;
    end
    if (i_rd && i_addr == ADDR_COLD_COEFF) begin
      rdata_d = cold_q;
    end else if (i_rd && i_addr == ADDR_CTRL_GAIN) begin
      rdata_d = ctrl_q;
    end else if (i_rd && i_addr == ADDR_STATUS) begin
      rdata_d = {5'h00, o_cold_span, sense_active, (state_q != ST_IDLE)};
    end
  end

  // Both enables come up cleared at power-up
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cold_q <= COLD_COEFF_RST;
      ctrl_q <= CTRL_GAIN_RST;
      rdata_q <= RDATA_NONE;
    end else begin
      cold_q <= cold_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

  // ------------------------------------------------------------
  // Sensing enables
  // ------------------------------------------------------------
  // Low battery overrides the battery enable bit outright
  assign sense_active = thermal_on && (!i_battery_mode || (batt_on && !i_vbat_low));

  // Trim path: sensing off bypasses the compensation engine
  always_comb begin
    if (sense_active) begin
      o_analog_trim = i_comp_analog_trim;
      o_digital_trim = i_comp_digital_trim;
    end else begin
      o_analog_trim = i_initial_analog_trim;
      o_digital_trim = i_initial_digital_trim;
    end
  end

  assign o_comp_active = sense_active;
  assign o_analog_step = trim_step(o_analog_trim);
  assign o_gain = ctrl_q[GAIN_MSB:0];

  // Coefficient select: the value is a magnitude, sign is implied negative
  assign o_cold_span = $signed(o_temp_result) < $signed(i_turnover_temp);
  assign o_curv_coeff = o_cold_span ? cold_q : i_hot_coeff;

  // ------------------------------------------------------------
  // Battery-mode sense period
  // ------------------------------------------------------------
  logic [31:0] div_q, div_d;
  logic [9:0] sec_q, sec_d;
  logic period_hit;
  logic [9:0] period_s;

  assign period_s = batt_rate ? PERIOD_FAST_S : PERIOD_SLOW_S;

  // Counters hold at zero whenever battery sensing is not live
  always_comb begin
    div_d = div_q;
    sec_d = sec_q;
    period_hit = 1'b0;
    if (!(i_battery_mode && sense_active)) begin
      div_d = '0;
      sec_d = '0;
    end else if (div_q == 32'(SECOND_CYCLES - 1)) begin
      div_d = '0;
      if (sec_q >= period_s - 10'h001) begin
        sec_d = '0;
        period_hit = 1'b1;
      end else begin
        sec_d = sec_q + 10'h001;
      end
    end else begin
      div_d = div_q + 32'h00000001;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      div_q <= '0;
      sec_q <= '0;
    end else begin
      div_q <= div_d;
      sec_q <= sec_d;
    end
  end

  // ------------------------------------------------------------
  // Two-conversion averaging sequencer
  // ------------------------------------------------------------
  logic [9:0] first_q, first_d;
  logic [9:0] temp_q, temp_d;
  logic start_q, start_d;
  logic [10:0] sum;

  assign sum = {1'b0, first_q} + {1'b0, i_conv_result};

  // Dropping sense enable mid-cycle abandons the pair, result untouched
  always_comb begin
    state_d = state_q;
    first_d = first_q;
    temp_d = temp_q;
    start_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start_ok || period_hit) begin
          state_d = ST_CONV1;
          start_d = 1'b1;
        end
      end
      ST_CONV1: begin
        // Off then on back to back restarts the pair at once
        if (!sense_active) begin
          state_d = start_ok ? ST_CONV1 : ST_IDLE;
          start_d = start_ok;
        end else if (i_conv_done) begin
          first_d = i_conv_result;
          state_d = ST_CONV2;
          start_d = 1'b1;
        end
      end
      ST_CONV2: begin
        if (!sense_active) begin
          state_d = start_ok ? ST_CONV1 : ST_IDLE;
          start_d = start_ok;
        end else if (i_conv_done) begin
          temp_d = sum[10:1];
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
      first_q <= '0;
      temp_q <= '0;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      first_q <= first_d;
      temp_q <= temp_d;
      start_q <= start_d;
    end
  end

  assign o_conv_start = start_q;
  assign o_temp_result = temp_q;
  // Sensor and converter draw power only while enabled
  assign o_sensor_on = sense_active && (state_q != ST_IDLE);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_second_done;
    (state_q == ST_CONV2) && sense_active && i_conv_done;
  endsequence

  sequence s_enable_write;
    start_ok;
  endsequence

  a_trim_decode: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (o_analog_trim == 6'h00 |-> o_analog_step == 7'sh20) and (o_analog_trim == 6'h3F |-> o_analog_step == -7'sh1F))
    else $error("analog trim step decode wrong");

  a_cold_select: assert property (@(posedge i_clock) disable iff (!i_nrst)
    o_cold_span |-> o_curv_coeff == cold_q)
    else $error("cold coefficient not applied below turnover");

  a_hot_select: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !o_cold_span |-> o_curv_coeff == i_hot_coeff)
    else $error("hot coefficient not applied above turnover");

  a_sense_gate: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !thermal_on |-> !o_sensor_on && !o_comp_active && (state_q == ST_IDLE || $past(thermal_on)))
    else $error("sensor active with sensing disabled");

  a_trim_bypass: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !thermal_on |-> o_analog_trim == i_initial_analog_trim && o_digital_trim == i_initial_digital_trim)
    else $error("initial trims not used while sensing off");

  a_enable_start: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_enable_write |=> o_conv_start && state_q == ST_CONV1)
    else $error("enable did not start a conversion");

  a_avg_stored: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_second_done |=> o_temp_result == $past(sum[10:1]) && state_q == ST_IDLE)
    else $error("average of two conversions not stored");

  a_batt_default: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_battery_mode && !batt_on |-> !o_comp_active)
    else $error("battery compensation without enable");

  a_vbat_low: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_battery_mode && i_vbat_low |-> !o_comp_active && !period_hit)
    else $error("compensation with low battery");

  a_period_bound: assert property (@(posedge i_clock) disable iff (!i_nrst)
    sec_q < PERIOD_SLOW_S && (sec_q < period_s || div_q != 32'(SECOND_CYCLES - 1) || period_hit ||
    !sense_active || !i_battery_mode))
    else $error("battery sense period overran");

endmodule : rtc_temp_comp

`default_nettype wire

// file: testbench/conv_model.sv
/*
  Converter model: answers each start pulse with a done pulse and a result.
  Assumes starts arrive one at a time from the block under test.
*/
`timescale 1ns/1ps
`default_nettype none

module conv_model #(
  parameter int DELAY = 3
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // Converter side
  input wire logic i_start,
  input wire logic [9:0] i_value,
  output logic o_done,
  output logic [9:0] o_result
);
  int cnt_q;
  logic odd_q;
  logic [9:0] res_q;

  // ------------------------------------------------------------
  // Conversion timing
  // ------------------------------------------------------------
  // Second result of a pair is two above the first
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 0;
      odd_q <= 1'b0;
      o_done <= 1'b0;
      res_q <= 10'h000;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt_q <= DELAY;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
        if (cnt_q == 1) begin
          o_done <= 1'b1;
          odd_q <= !odd_q;
          res_q <= i_value + {8'h00, odd_q, 1'b0};
        end
      end
    end
  end

  // Result is only valid with done, so it shows the inverted result otherwise
  always_comb begin
    o_result = o_done ? res_q : ~res_q;
  end
endmodule : conv_model

`default_nettype wire

// file: testbench/tb.sv
/*
  Testbench for the compensation control block: register port tasks,
  trim decode, coefficient span, averaging and battery sense period.
  Assumes the converter model answers every start pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import rtc_tc_pkg::*;
  localparam int SC = 4;
  logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic bat = 1'b0, vlow = 1'b0, done, start, son, act, cold;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, curv;
  logic [5:0] iat = 6'h00, oat;
  logic [4:0] idt = 5'h05, odt, gain;
  logic [9:0] turn = 10'h000, res, temp;
  logic signed [6:0] step;
  int n_fail = 0, checks_done = 0, k, j;

  // ------------------------------------------------------------
  // Instances and clock
  // ------------------------------------------------------------
  always #4 clk = ~clk;
  rtc_temp_comp #(.SECOND_CYCLES(SC)) dut (.i_clock(clk), .i_nrst(nrst),
    .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_battery_mode(bat), .i_vbat_low(vlow), .i_initial_analog_trim(iat),
    .i_initial_digital_trim(idt), .i_comp_analog_trim(6'h15),
    .i_comp_digital_trim(5'h0A), .i_hot_coeff(8'h33), .i_turnover_temp(turn),
    .i_conv_done(done), .i_conv_result(res), .o_conv_start(start),
    .o_sensor_on(son), .o_comp_active(act), .o_analog_trim(oat),
    .o_digital_trim(odt), .o_analog_step(step), .o_gain(gain),
    .o_curv_coeff(curv), .o_cold_span(cold), .o_temp_result(temp));
  conv_model cm (.i_clock(clk), .i_nrst(nrst), .i_start(start),
    .i_value(10'h050), .o_done(done), .o_result(res));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr

  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", {2'b00, e}, {2'b00, rdata});
    @(posedge clk);
    #1 chk("rdata idle", 10'h000, {2'b00, rdata});
  endtask : rdc

  // Waits for a start pulse, reporting the cycles spent
  task automatic wst(input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (start !== 1'b1 && c < lim);
  endtask : wst

  task automatic per(input logic r, input int p);
    wrr(ADDR_CTRL_GAIN, 8'h00);
    wrr(ADDR_CTRL_GAIN, {2'b11, r, 5'h00});
    #1 chk("bat start", 10'h001, {9'h0, start});
    wst(100, k);
    wst(p * SC + 100, k);
    wst(100, k);
    wst(3000, j);
    chk("period", 10'h001, 10'(k + j == p * SC));
  endtask : per

  task automatic stop_test;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rdc(ADDR_COLD_COEFF, COLD_COEFF_RST);
    rdc(ADDR_CTRL_GAIN, 8'h00);
    chk("sensor", 10'h000, {9'h0, son});
    rdc(8'h55, 8'h00);
    $display("test reset done");
    // Every analog code, sensing off
    for (int c = 0; c < 64; c++) begin
      @(posedge clk);
      iat <= 6'(c);
      #1 chk("step", {3'h0, 7'(32 - c)}, {3'h0, step});
      chk("atrim", 10'(c), {4'h0, oat});
      chk("dtrim", 10'h005, {5'h0, odt});
    end
    $display("test trim done");
    wrr(ADDR_COLD_COEFF, 8'h46);
    rdc(ADDR_COLD_COEFF, 8'h46);
    @(posedge clk);
    turn <= 10'h064;
    #1 chk("cold", 10'h046, {2'b00, curv});
    @(posedge clk);
    turn <= 10'h3F0;
    #1 chk("hot", 10'h033, {2'b00, curv});
    $display("test coeff done");
    wrr(ADDR_CTRL_GAIN, 8'h80);
    #1 chk("start", 10'h001, {9'h0, start});
    chk("sensor on", 10'h001, {9'h0, son});
    k = 0;
    while (temp === 10'h000 && k < 100) begin
      @(posedge clk);
      #1 k++;
    end
    chk("average", 10'h051, temp);
    chk("active", 10'h001, {9'h0, act});
    chk("comp trim", 10'h015, {4'h0, oat});
    chk("comp dtrim", 10'h00A, {5'h0, odt});
    rdc(ADDR_STATUS, 8'h02);
    wrr(ADDR_CTRL_GAIN, 8'h00);
    wrr(ADDR_CTRL_GAIN, 8'h1F);
    rdc(ADDR_CTRL_GAIN, 8'h1F);
    chk("gain", 10'h01F, {5'h0, gain});
    chk("init trim", {4'h0, iat}, {4'h0, oat});
    $display("test average done");
    @(posedge clk);
    bat <= 1'b1;
    vlow <= 1'b1;
    wrr(ADDR_CTRL_GAIN, 8'hC0);
    #1 chk("low wr start", 10'h000, {9'h0, start});
    wst(300, k);
    chk("low start", 10'h12C, 10'(k));
    chk("low sense", 10'h000, {8'h0, son, act});
    @(posedge clk);
    vlow <= 1'b0;
    wrr(ADDR_CTRL_GAIN, 8'h00);
    wrr(ADDR_CTRL_GAIN, 8'h80);
    #1 chk("no battery_sensing_on", 10'h000, {8'h0, son, start});
    per(1'b1, 60);
    per(1'b0, 600);
    $display("test battery done");
    stop_test();
  end

  // Watchdog reckoned well beyond the longest test
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule : tb

`default_nettype wire
